// ===== hw/rxsc_top.sv
// receive special-character compare, good-byte count, modem fall detect and auto DTR
`timescale 1ns/1ps
`default_nettype none
module rxsc_top import rxsc_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic [3:0] rx_fifo_level,
  input wire logic rx_int_pulse,
  input wire logic dsr_n,
  input wire logic cd_n,
  input wire logic cts_n,
  output logic stat_valid,
  output var rxsc_stat_s stat_entry,
  output logic dtr_n,
  output logic rts_n,
  output logic irq
);
  // ==========================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [2:0] pin_meta_reg, pin_sync_reg, pin_prev_reg;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  // modem state bits are active high: inverted pins, order dsr, cd, cts
  wire logic [2:0] modem_now = ~pin_sync_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 3'b111;
      pin_sync_reg <= 3'b111;
      pin_prev_reg <= 3'b111;
    end else begin
      pin_meta_reg <= {dsr_n, cd_n, cts_n};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // ==========================================
  // matching functions
  function automatic logic [2:0] single_code(input logic [7:0] c, input logic [7:0] s1,
      input logic [7:0] s2, input logic [7:0] s3, input logic [7:0] s4);
    if (c == s1) return MATCH_ONE;
    else if (c == s2) return MATCH_TWO;
    else if (c == s3) return MATCH_THREE;
    else if (c == s4) return MATCH_FOUR;
    else return MATCH_NONE;
  endfunction : single_code

  function automatic logic mapped(input logic [5:0] idx);
    return idx inside {IDX_GOOD_CNT, IDX_SPECIAL_CHAR_ONE, IDX_SPECIAL_CHAR_TWO, IDX_SPECIAL_CHAR_THREE, IDX_SPECIAL_CHAR_FOUR,
      IDX_MODEM_OPT, IDX_CHG_FLAGS, IDX_CHG_CLEAR, IDX_CHG_ENABLE, IDX_CHAR_CFG,
      IDX_SIG_VALUE};
  endfunction : mapped

  // ==========================================
  // register file
  logic [7:0] good_cnt_reg, good_cnt_next;
  logic [7:0] special_char_one_reg, special_char_one_next, special_char_two_reg, special_char_two_next;
  logic [7:0] special_char_three_reg, special_char_three_next, special_char_four_reg, special_char_four_next;
  logic [7:0] opt_reg, opt_next, flags_reg, flags_next, enable_reg, enable_next;
  logic [7:0] cfg_reg, cfg_next, sig_reg, sig_next;
  logic [31:0] prdata_next;
  logic match_event;
  logic [2:0] fall_event;
  wire logic [5:0] idx = paddr[7:2];
  wire logic aligned = (paddr[1:0] == 2'b00);
  wire logic wr_go = psel & penable & pwrite & aligned;
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic [3:0] thr = opt_reg[THR_MSB:0];
  wire logic auto_dtr_on = (thr != THR_OFF) && (thr <= MAX_COUNT);
  wire logic dual_en = cfg_reg[BIT_DUAL];

  // falling pin edge, enabled per option bit
  assign fall_event[2] = opt_reg[BIT_DSR] & pin_prev_reg[2] & ~pin_sync_reg[2];
  assign fall_event[1] = opt_reg[BIT_CD] & pin_prev_reg[1] & ~pin_sync_reg[1];
  assign fall_event[0] = opt_reg[BIT_CTS] & pin_prev_reg[0] & ~pin_sync_reg[0];

  always_comb begin
    good_cnt_next = good_cnt_reg;
    special_char_one_next = special_char_one_reg;
    special_char_two_next = special_char_two_reg;
    special_char_three_next = special_char_three_reg;
    special_char_four_next = special_char_four_reg;
    opt_next = opt_reg;
    flags_next = flags_reg;
    enable_next = enable_reg;
    cfg_next = cfg_reg;
    sig_next = sig_reg;
    prdata_next = prdata;
    if (rx_int_pulse) begin
      // count saturates at eight, upper nibble always zero
      good_cnt_next = {4'h0, (rx_fifo_level > MAX_COUNT) ? MAX_COUNT : rx_fifo_level};
    end
    if (wr_go) begin
      unique case (idx)
        IDX_SPECIAL_CHAR_ONE: special_char_one_next = wbyte;
        IDX_SPECIAL_CHAR_TWO: special_char_two_next = wbyte;
        IDX_SPECIAL_CHAR_THREE: special_char_three_next = wbyte;
        IDX_SPECIAL_CHAR_FOUR: special_char_four_next = wbyte;
        IDX_MODEM_OPT: opt_next = wbyte & 8'hEF;
        IDX_CHG_CLEAR: flags_next = flags_reg & ~(wbyte & FLAG_MASK);
        IDX_CHG_ENABLE: enable_next = wbyte & FLAG_MASK;
        IDX_CHAR_CFG: cfg_next = wbyte & 8'h01;
        IDX_SIG_VALUE: sig_next = wbyte & 8'h03;
        default: ;
      endcase
    end
    // set wins over clear in the same cycle
    flags_next[BIT_DSR:BIT_CTS] = flags_next[BIT_DSR:BIT_CTS] | fall_event;
    flags_next[BIT_MATCH] = flags_next[BIT_MATCH] | match_event;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      unique case (idx)
        IDX_GOOD_CNT: prdata_next[7:0] = good_cnt_reg;
        IDX_SPECIAL_CHAR_ONE: prdata_next[7:0] = special_char_one_reg;
        IDX_SPECIAL_CHAR_TWO: prdata_next[7:0] = special_char_two_reg;
        IDX_SPECIAL_CHAR_THREE: prdata_next[7:0] = special_char_three_reg;
        IDX_SPECIAL_CHAR_FOUR: prdata_next[7:0] = special_char_four_reg;
        IDX_MODEM_OPT: prdata_next[7:0] = opt_reg;
        IDX_CHG_FLAGS: prdata_next[7:0] = flags_reg;
        IDX_CHG_ENABLE: prdata_next[7:0] = enable_reg;
        IDX_CHAR_CFG: prdata_next[7:0] = cfg_reg;
        IDX_SIG_VALUE: prdata_next[7:0] = {modem_now, 3'b000, ~dtr_n, sig_reg[BIT_RTS]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      good_cnt_reg <= RST_BYTE;
      special_char_one_reg <= RST_BYTE;
      special_char_two_reg <= RST_BYTE;
      special_char_three_reg <= RST_BYTE;
      special_char_four_reg <= RST_BYTE;
      opt_reg <= RST_BYTE;
      flags_reg <= RST_BYTE;
      enable_reg <= RST_BYTE;
      cfg_reg <= RST_BYTE;
      sig_reg <= RST_BYTE;
      prdata <= 32'h0000_0000;
    end else begin
      good_cnt_reg <= good_cnt_next;
      special_char_one_reg <= special_char_one_next;
      special_char_two_reg <= special_char_two_next;
      special_char_three_reg <= special_char_three_next;
      special_char_four_reg <= special_char_four_next;
      opt_reg <= opt_next;
      flags_reg <= flags_next;
      enable_reg <= enable_next;
      cfg_reg <= cfg_next;
      sig_reg <= sig_next;
      prdata <= prdata_next;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & (~aligned | ~mapped(idx) | (~pwrite & (idx == IDX_CHG_CLEAR)));
  assign irq = |(flags_reg & enable_reg);

  // ==========================================
  // special character compare and status entry
  rxsc_state_e state_reg, state_next;
  logic [7:0] held_reg, held_next;
  logic [2:0] kind_reg, kind_next, hmatch_reg, hmatch_next;
  logic stat_valid_next;
  rxsc_stat_s entry_next;
  wire logic [2:0] cur_code = single_code(rx_char, special_char_one_reg, special_char_two_reg, special_char_three_reg, special_char_four_reg);

  always_comb begin
    state_next = state_reg;
    held_next = held_reg;
    kind_next = kind_reg;
    hmatch_next = hmatch_reg;
    stat_valid_next = 1'b0;
    entry_next = stat_entry;
    unique case (state_reg)
      RXSC_IDLE: begin
        if (rx_char_valid) begin
          if (dual_en && (cur_code == MATCH_ONE || cur_code == MATCH_TWO)) begin
            held_next = rx_char;
            kind_next = cur_code;
            state_next = RXSC_PEND;
          end else begin
            stat_valid_next = 1'b1;
            entry_next = '{data: rx_char, match: cur_code};
          end
        end
      end
      RXSC_PEND: begin
        if (rx_char_valid) begin
          stat_valid_next = 1'b1;
          if (kind_reg == MATCH_ONE && rx_char == special_char_three_reg) begin
            entry_next = '{data: held_reg, match: MATCH_XON_SEQ};
            hmatch_next = MATCH_NONE;
          end else if (kind_reg == MATCH_TWO && rx_char == special_char_four_reg) begin
            entry_next = '{data: held_reg, match: MATCH_XOFF_SEQ};
            hmatch_next = MATCH_NONE;
          end else begin
            entry_next = '{data: held_reg, match: kind_reg};
            hmatch_next = cur_code;
          end
          held_next = rx_char;
          state_next = RXSC_FLUSH;
        end
      end
      RXSC_FLUSH: begin
        stat_valid_next = 1'b1;
        entry_next = '{data: held_reg, match: hmatch_reg};
        state_next = RXSC_IDLE;
      end
      default: state_next = RXSC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RXSC_IDLE;
      held_reg <= RST_BYTE;
      kind_reg <= MATCH_NONE;
      hmatch_reg <= MATCH_NONE;
      stat_valid <= 1'b0;
      stat_entry <= '0;
    end else begin
      state_reg <= state_next;
      held_reg <= held_next;
      kind_reg <= kind_next;
      hmatch_reg <= hmatch_next;
      stat_valid <= stat_valid_next;
      stat_entry <= entry_next;
    end
  end
  assign match_event = stat_valid_next & (entry_next.match != MATCH_NONE);

  // ==========================================
  // modem outputs with automatic DTR
  logic dtr_n_next;
  always_comb begin
    if (auto_dtr_on) begin
      dtr_n_next = (rx_fifo_level >= thr);
    end else begin
      dtr_n_next = ~sig_reg[BIT_DTR];
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n <= 1'b1;
    end else begin
      dtr_n <= dtr_n_next;
    end
  end
  assign rts_n = ~sig_reg[BIT_RTS];

  // ==========================================
  // checks
  chk_count_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_int_pulse |=> good_cnt_reg[7:4] == 4'h0 && good_cnt_reg[3:0] <= MAX_COUNT)
    else $error("good count out of range");
  chk_single_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == RXSC_IDLE && rx_char_valid && !dual_en && rx_char == special_char_three_reg
     && rx_char != special_char_one_reg && rx_char != special_char_two_reg)
    |=> stat_valid && stat_entry.match == MATCH_THREE)
    else $error("special three match not flagged");
  chk_pair_withheld: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == RXSC_IDLE && rx_char_valid && dual_en && rx_char == special_char_one_reg)
    |=> !stat_valid && state_reg == RXSC_PEND)
    else $error("first half entry not withheld");
  chk_xon_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == RXSC_PEND && rx_char_valid && kind_reg == MATCH_ONE && rx_char == special_char_three_reg)
    |=> stat_valid && stat_entry.match == MATCH_XON_SEQ ##1 stat_valid)
    else $error("xon pair not reported");
  chk_xoff_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_reg == RXSC_PEND && rx_char_valid && kind_reg == MATCH_TWO && rx_char == special_char_four_reg)
    |=> stat_valid && stat_entry.match == MATCH_XOFF_SEQ)
    else $error("xoff pair not reported");
  chk_dsr_fall_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (opt_reg[BIT_DSR] && $fell(pin_sync_reg[2])) |=> flags_reg[BIT_DSR])
    else $error("dsr fall not flagged");
  chk_cd_masked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!opt_reg[BIT_CD] && !flags_reg[BIT_CD]) |=> !flags_reg[BIT_CD])
    else $error("cd flag set while disabled");
  chk_cts_fall_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (opt_reg[BIT_CTS] && $fell(pin_sync_reg[0])) |=> flags_reg[BIT_CTS])
    else $error("cts fall not flagged");
  chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (flags_reg[BIT_DSR] && enable_reg[BIT_DSR]) |-> irq)
    else $error("irq low with enabled flag");
  chk_auto_dtr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (auto_dtr_on && rx_fifo_level >= thr) |=> dtr_n)
    else $error("dtr not dropped at threshold");
endmodule : rxsc_top
`default_nettype wire

// ===== hw/rxsc_pkg.sv
// constants, states and carriers of the receive special-character and modem-detect block
package rxsc_pkg;
  // ==========================================
  // register indices (byte address = 4 * index)
  localparam logic [5:0] IDX_GOOD_CNT = 6'h07;
  localparam logic [5:0] IDX_SPECIAL_CHAR_ONE = 6'h09;
  localparam logic [5:0] IDX_SPECIAL_CHAR_TWO = 6'h0A;
  localparam logic [5:0] IDX_SPECIAL_CHAR_THREE = 6'h0B;
  localparam logic [5:0] IDX_SPECIAL_CHAR_FOUR = 6'h0C;
  localparam logic [5:0] IDX_MODEM_OPT = 6'h10;
  localparam logic [5:0] IDX_CHG_FLAGS = 6'h12;
  localparam logic [5:0] IDX_CHG_CLEAR = 6'h13;
  localparam logic [5:0] IDX_CHG_ENABLE = 6'h14;
  localparam logic [5:0] IDX_CHAR_CFG = 6'h15;
  localparam logic [5:0] IDX_SIG_VALUE = 6'h28;
  // ==========================================
  // field positions
  localparam int BIT_DSR = 7;
  localparam int BIT_CD = 6;
  localparam int BIT_CTS = 5;
  localparam int BIT_MATCH = 4;
  localparam int BIT_DTR = 1;
  localparam int BIT_RTS = 0;
  localparam int BIT_DUAL = 0;
  localparam int THR_MSB = 3;
  localparam logic [7:0] FLAG_MASK = 8'hF0;
  // ==========================================
  // reset values and counts
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] MAX_COUNT = 4'h8;
  localparam logic [3:0] THR_OFF = 4'h0;
  // ==========================================
  // match codes carried with each status entry
  localparam logic [2:0] MATCH_NONE = 3'h0;
  localparam logic [2:0] MATCH_ONE = 3'h1;
  localparam logic [2:0] MATCH_TWO = 3'h2;
  localparam logic [2:0] MATCH_THREE = 3'h3;
  localparam logic [2:0] MATCH_FOUR = 3'h4;
  localparam logic [2:0] MATCH_XON_SEQ = 3'h5;
  localparam logic [2:0] MATCH_XOFF_SEQ = 3'h6;
  typedef enum logic [1:0] {
    RXSC_IDLE = 2'b00,
    RXSC_PEND = 2'b01,
    RXSC_FLUSH = 2'b10
  } rxsc_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] match;
  } rxsc_stat_s;
endpackage : rxsc_pkg

// ===== verification/rxsc_remote.sv
// remote serial device and modem model that feeds the receive side
`timescale 1ns/1ps
`default_nettype none
module rxsc_remote (
  input wire logic sys_clk,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic dsr_n,
  output logic cd_n,
  output logic cts_n
);
  initial begin
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    {dsr_n, cd_n, cts_n} = 3'b111;
  end
  // one character, then idle long enough to cover a pair flush cycle
  task automatic send(input logic [7:0] c);
    @(posedge sys_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge sys_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
    repeat (3) @(posedge sys_clk);
  endtask : send
  // active-low pin levels {dsr, cd, cts}
  task automatic pins(input logic [2:0] lvl);
    @(posedge sys_clk);
    {dsr_n, cd_n, cts_n} <= lvl;
  endtask : pins
endmodule : rxsc_remote
`default_nettype wire

// ===== verification/rxsc_top_tb.sv
// self-checking bench of the receive special-character and modem-detect block
`timescale 1ns/1ps
`default_nettype none
module rxsc_top_tb import rxsc_pkg::*; ;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] rx_fifo_level = 4'h0;
  logic rx_int_pulse = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, stat_valid, dtr_n, rts_n, irq, rx_char_valid, dsr_n, cd_n, cts_n;
  logic [7:0] rx_char;
  rxsc_stat_s stat_entry;
  rxsc_stat_s sq[$];
  logic [7:0] sc [4] = '{8'h11, 8'h13, 8'h12, 8'h14};
  int failures = 0;
  int checks = 0;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (stat_valid === 1'b1) sq.push_back(stat_entry);
  end

  rxsc_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_fifo_level(rx_fifo_level), .rx_int_pulse(rx_int_pulse), .dsr_n(dsr_n), .cd_n(cd_n),
    .cts_n(cts_n), .stat_valid(stat_valid), .stat_entry(stat_entry), .dtr_n(dtr_n),
    .rts_n(rts_n), .irq(irq));
  rxsc_remote rem (.sys_clk(sys_clk), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .dsr_n(dsr_n), .cd_n(cd_n), .cts_n(cts_n));

  // ==========================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge sys_clk);
  endtask : apb
  task automatic rchk(input string nm, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rd, exp);
  endtask : rchk
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // ==========================================
  // scenarios
  task automatic t_regs();
    rchk("char1 reset", IDX_SPECIAL_CHAR_ONE, 32'h0);
    for (int i = 0; i < 4; i++) apb(1'b1, 6'(IDX_SPECIAL_CHAR_ONE + i), {24'h0, sc[i]});
    for (int i = 0; i < 4; i++) rchk("char rd", 6'(IDX_SPECIAL_CHAR_ONE + i), {24'h0, sc[i]});
    apb(1'b1, IDX_MODEM_OPT, 32'hFF);
    rchk("options", IDX_MODEM_OPT, 32'hEF);
    apb(1'b1, IDX_MODEM_OPT, 32'h0);
    apb(1'b1, IDX_GOOD_CNT, 32'hFF);
    rchk("count ro", IDX_GOOD_CNT, 32'h0);
    apb(1'b1, 6'h3F, 32'hFF);
    chk("unmapped err", 32'(er), 32'h1);
    rchk("unmapped rd", 6'h3F, 32'h0);
    chk("ready", 32'(pready), 32'h1);
    rchk("clear rd", IDX_CHG_CLEAR, 32'h0);
    chk("clear rd err", 32'(er), 32'h1);
  endtask : t_regs
  task automatic t_count();
    for (int k = 1; k <= 8; k += 7) begin
      @(posedge sys_clk);
      rx_fifo_level <= 4'(k);
      rx_int_pulse <= 1'b1;
      @(posedge sys_clk);
      rx_int_pulse <= 1'b0;
      rx_fifo_level <= 4'h3;
      rchk("good count", IDX_GOOD_CNT, 32'(k));
    end
  endtask : t_count
  task automatic t_single();
    sq.delete();
    for (int i = 0; i < 4; i++) rem.send(sc[i]);
    rem.send(8'h55);
    chk("entries", 32'(sq.size()), 32'h5);
    for (int i = 0; i < 4; i++) chk("match", 32'(sq[i]), {21'h0, sc[i], 3'(i + 1)});
    chk("no match", 32'(sq[4]), {21'h0, 8'h55, MATCH_NONE});
    rchk("match flag", IDX_CHG_FLAGS, 32'h10);
    apb(1'b1, IDX_CHG_CLEAR, 32'hFF);
  endtask : t_single
  task automatic t_dual();
    logic [7:0] fa [3] = '{8'h11, 8'h13, 8'h13};
    logic [7:0] sb [3] = '{8'h12, 8'h14, 8'h55};
    logic [2:0] cd [3] = '{MATCH_XON_SEQ, MATCH_XOFF_SEQ, MATCH_TWO};
    apb(1'b1, IDX_CHAR_CFG, 32'h1);
    for (int i = 0; i < 3; i++) begin
      sq.delete();
      rem.send(fa[i]);
      repeat (6) @(posedge sys_clk);
      chk("held", 32'(sq.size()), 32'h0);
      rem.send(sb[i]);
      chk("pair count", 32'(sq.size()), 32'h2);
      chk("first", 32'(sq[0]), {21'h0, fa[i], cd[i]});
      chk("second", 32'(sq[1]), {21'h0, sb[i], MATCH_NONE});
    end
    apb(1'b1, IDX_CHAR_CFG, 32'h0);
    apb(1'b1, IDX_CHG_CLEAR, 32'hFF);
  endtask : t_dual
  task automatic t_modem();
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, IDX_CHG_ENABLE, 32'h0);
      apb(1'b1, IDX_MODEM_OPT, 32'h80 >> i);
      rem.pins(3'b000);
      repeat (8) @(posedge sys_clk);
      rchk("fall flag", IDX_CHG_FLAGS, 32'h80 >> i);
      chk("irq masked", 32'(irq), 32'h0);
      rchk("pin value", IDX_SIG_VALUE, 32'hE0);
      apb(1'b1, IDX_CHG_ENABLE, 32'h80 >> i);
      chk("irq on", 32'(irq), 32'h1);
      apb(1'b1, IDX_CHG_CLEAR, 32'h80 >> i);
      chk("irq off", 32'(irq), 32'h0);
      rem.pins(3'b111);
      repeat (8) @(posedge sys_clk);
      rchk("rise ignored", IDX_CHG_FLAGS, 32'h0);
    end
  endtask : t_modem
  task automatic t_dtr();
    logic [3:0] th [6] = '{4'h3, 4'h3, 4'h3, 4'h8, 4'h8, 4'h0};
    logic [3:0] lv [6] = '{4'h2, 4'h3, 4'h2, 4'h8, 4'h7, 4'h8};
    logic ex [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, IDX_MODEM_OPT, {28'h0, th[i]});
      @(posedge sys_clk);
      rx_fifo_level <= lv[i];
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("dtr auto", 32'(dtr_n), 32'(ex[i]));
    end
    apb(1'b1, IDX_SIG_VALUE, 32'h2);
    // dtr_n is registered one edge behind the signal register
    @(negedge sys_clk);
    chk("dtr manual", {dtr_n, rts_n}, 32'h1);
    apb(1'b1, IDX_SIG_VALUE, 32'h1);
    @(negedge sys_clk);
    chk("rts manual", {dtr_n, rts_n}, 32'h2);
  endtask : t_dtr

  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    t_regs();
    t_count();
    t_single();
    t_dual();
    t_modem();
    t_dtr();
    results();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    $display("watchdog expired");
    results();
  end
endmodule : rxsc_top_tb
`default_nettype wire
